//--- rtl/tbrw_pkg.sv
// Purpose: Shared constants for the tag block write and data read commands.
// Assumes: A 32-bit APB register port and a byte-wide argument list.
// Notes: Blocks below 0x80 sit in 4-block sectors, the rest in 16-block ones.
package tbrw_pkg;
	// Command codes taken from the command register.
	localparam logic [7:0] CMD_WRITE = 8'h03;
	localparam logic [7:0] CMD_READ_DATA = 8'h04;
	// Byte positions inside the packed argument list.
	localparam int ARG_START = 0;
	localparam int ARG_COUNT = 1;
	localparam int ARG_OFFSET = 2;
	localparam int ARG_KEYSEL = 3;
	localparam int ARG_KEY = 4;
	localparam int KEY_BYTES = 6;
	localparam int ARG_BYTES = 10;
	// Key selector fields.
	localparam int KEYSEL_B_BIT = 7;
	localparam int KEYSEL_INLINE_BIT = 6;
	localparam int KEY_INDEX_BITS = 6;
	localparam logic [5:0] KEY_MAX = 6'h27;
	localparam int NUM_KEYS = 40;
	// Tag geometry and buffer size.
	localparam int BLOCK_BYTES = 16;
	localparam logic [7:0] BLOCK_STEP = 8'h10;
	localparam int BUF_BYTES = 256;
	localparam logic [7:0] LARGE_SECTOR_BASE = 8'h80;
	// Result codes and the value after reset.
	localparam logic [7:0] RES_OK = 8'h00;
	localparam logic [7:0] RES_AUTH = 8'h01;
	localparam logic [7:0] RES_TAG = 8'h02;
	localparam logic [7:0] RES_ARG = 8'h03;
	localparam logic [7:0] RES_CMD = 8'h04;
	localparam logic [7:0] RESULT_RESET = 8'h00;
	// Tag operation codes.
	localparam logic [1:0] OP_AUTH = 2'h1;
	localparam logic [1:0] OP_WRITE = 2'h2;
	localparam logic [1:0] OP_READ = 2'h3;
	// APB byte addresses.
	localparam logic [11:0] ADDR_RESULT = 12'h000;
	localparam logic [11:0] ADDR_COMMAND = 12'h004;
	localparam logic [11:0] ADDR_ARG0 = 12'h008;
	localparam logic [11:0] ADDR_ARG1 = 12'h00c;
	localparam logic [11:0] ADDR_ARG2 = 12'h010;
	localparam logic [11:0] ADDR_STATUS = 12'h014;
	localparam logic [11:0] ADDR_KEY_INDEX = 12'h018;
	localparam logic [11:0] ADDR_KEY_LO = 12'h01c;
	localparam logic [11:0] ADDR_KEY_HI = 12'h020;
	localparam logic [3:0] ADDR_BUF_PAGE = 4'h1;
	// Sector number of a block.
	function automatic logic [5:0] tbrw_sector(input logic [7:0] blk);
		tbrw_sector = (blk < LARGE_SECTOR_BASE) ? {1'b0, blk[6:2]} :
			{3'b100, blk[6:4]};
	endfunction
	// True for the last block of a sector, which holds keys and lock bits.
	function automatic logic tbrw_trailer(input logic [7:0] blk);
		tbrw_trailer = (blk < LARGE_SECTOR_BASE) ? (blk[1:0] == 2'h3) :
			(blk[3:0] == 4'hf);
	endfunction
endpackage

//--- rtl/tbrw_block_cmds.sv
// Purpose: Runs the block write and data block read commands toward a tag.
// Assumes: Tag link answers each request with a one-cycle tag_done pulse.
// Notes: Registers, argument list, key store and data buffer are on APB.
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// RL1: code 03 starts a multi-block write
// RL2: code 04 reads data blocks, same arguments
// RL3: start, count, offset, selector, then six-byte key
// RL4: host gives a block count above zero
// RL5: host keeps offset plus size inside buffer
// RL6: selector low six bits pick stored key
// RL7: selector bit 7 chooses key B
// RL8: selector bit 6 takes the inline key
// RL9: inline key is least significant byte first
// RL10: authenticate first sector before any transfer
// RL11: write auth failure ends without writing
// RL12: write copies buffer from offset into blocks
// RL13: new sector is authenticated again, same key
// RL14: complete write reports success
// RL15: failed block write reports an error
// RL16: read auth failure stores error and stops
// RL17: read fetches blocks, re-authenticating per sector
// RL18: data read skips sector trailer blocks
// RL19: read bytes land contiguously, success reported
// RL20: failed block read reports an error
// RL21: result held and commands ignored while busy
module tbrw_block_cmds import tbrw_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic tag_req,
	output logic [1:0] tag_op,
	output logic [7:0] tag_block,
	output logic [47:0] tag_key,
	output logic tag_key_b,
	output logic [127:0] tag_wdata,
	input wire logic tag_done,
	input wire logic tag_ok,
	input wire logic [127:0] tag_rdata
);
	// Command sequencer states.
	typedef enum logic [2:0] {S_IDLE, S_CHECK, S_AUTH, S_XFER} tbrw_state_t;
	tbrw_state_t state; // Current sequencer state.
	logic busy; // High while a command runs.
	logic [7:0] result; // Result code shown to software.
	logic [7:0] cur_cmd; // Command being executed.
	logic [7:0] blk; // Next tag block to handle.
	logic [7:0] cnt; // Blocks still to transfer.
	logic [7:0] ptr; // Buffer byte address of the next block.
	logic authed; // A sector is currently authenticated.
	logic [5:0] auth_sector; // The sector that is authenticated.
	logic [7:0] arg_mem [ARG_BYTES]; // Packed argument list.
	logic [47:0] key_store [NUM_KEYS]; // Stored keys.
	logic [5:0] key_index; // Stored key slot that software loads.
	logic [31:0] key_lo; // Low key word held until the high word comes.
	logic [7:0] buf_mem [BUF_BYTES]; // Shared data buffer.
	// Bus phase decode; the write lands at the access edge only.
	wire logic setup_ph = psel & ~penable;
	wire logic wr_acc = psel & penable & pready & pwrite;
	// RL21: new commands ignored while busy
	wire logic start_cmd = wr_acc && (paddr == ADDR_COMMAND) && !busy;
	wire logic key_inline = arg_mem[ARG_KEYSEL][KEYSEL_INLINE_BIT];
	logic [47:0] inline_key; // Key assembled from the argument list.
	logic [47:0] stored_key; // Key read from the store.
	logic [7:0] arg_err; // Error code for bad arguments, zero if none.
	// Returns true for every address that the slave answers.
	function automatic logic tbrw_mapped(input logic [11:0] a);
		tbrw_mapped = (a[11:8] == ADDR_BUF_PAGE) || (a == ADDR_RESULT) ||
			(a == ADDR_COMMAND) || (a == ADDR_ARG0) || (a == ADDR_ARG1) ||
			(a == ADDR_ARG2) || (a == ADDR_STATUS) ||
			(a == ADDR_KEY_INDEX) || (a == ADDR_KEY_LO) ||
			(a == ADDR_KEY_HI);
	endfunction
	// Key selection; an out-of-range slot yields zero, and an argument error unless the key is inline.
	always_comb begin
		for (int i = 0; i < KEY_BYTES; i++) begin
			// RL9: first argument byte is the least significant
			inline_key[8*i +: 8] = arg_mem[ARG_KEY + i];
		end
		// RL6: low six selector bits index the store
		stored_key = (arg_mem[ARG_KEYSEL][KEY_INDEX_BITS-1:0] <= KEY_MAX) ?
			key_store[arg_mem[ARG_KEYSEL][KEY_INDEX_BITS-1:0]] : 48'h0;
	end
	// Argument checks; the count check protects against a host slip.
	always_comb begin
		// RL1 RL2: only the two block codes run
		if ((pwdata[7:0] != CMD_WRITE) && (pwdata[7:0] != CMD_READ_DATA)) begin
			arg_err = RES_CMD;
		end else if ((arg_mem[ARG_COUNT] == 8'h00) || (!key_inline &&
			(arg_mem[ARG_KEYSEL][KEY_INDEX_BITS-1:0] > KEY_MAX))) begin
			arg_err = RES_ARG;
		end else begin
			arg_err = 8'h00;
		end
	end
	// The slave answers in the cycle after setup, so each access is one cycle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup_ph;
			pslverr <= setup_ph && !tbrw_mapped(paddr);
		end
	end
	// Read data is prepared during setup so it is stable in the access phase.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0;
		end else if (setup_ph && !pwrite) begin
			if (paddr[11:8] == ADDR_BUF_PAGE) begin
				prdata <= {buf_mem[{paddr[7:2], 2'h3}],
					buf_mem[{paddr[7:2], 2'h2}],
					buf_mem[{paddr[7:2], 2'h1}], buf_mem[{paddr[7:2], 2'h0}]};
			end else begin
				case (paddr)
					ADDR_RESULT: prdata <= {24'h0, result};
					ADDR_COMMAND: prdata <= {24'h0, cur_cmd};
					ADDR_ARG0: prdata <= {arg_mem[3], arg_mem[2], arg_mem[1],
						arg_mem[0]};
					ADDR_ARG1: prdata <= {arg_mem[7], arg_mem[6], arg_mem[5],
						arg_mem[4]};
					ADDR_ARG2: prdata <= {16'h0, arg_mem[9], arg_mem[8]};
					ADDR_STATUS: prdata <= {16'h0, cnt, 6'h0, authed, busy};
					ADDR_KEY_INDEX: prdata <= {26'h0, key_index};
					// Keys are never read back.
					default: prdata <= 32'h0;
				endcase
			end
		end
	end
	// Argument list; frozen while a command runs so the key cannot shift.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < ARG_BYTES; i++) begin
				arg_mem[i] <= 8'h00;
			end
		end else if (wr_acc && !busy) begin
			// RL3: words map onto byte positions of the list
			if ((paddr == ADDR_ARG0) || (paddr == ADDR_ARG1)) begin
				for (int i = 0; i < 4; i++) begin
					arg_mem[{paddr[2], 2'(i)}] <= pwdata[8*i +: 8];
				end
			end else if (paddr == ADDR_ARG2) begin
				arg_mem[8] <= pwdata[7:0];
				arg_mem[9] <= pwdata[15:8];
			end
		end
	end
	// Key store; a slot is committed when its high word is written.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			key_index <= 6'h0;
			key_lo <= 32'h0;
			for (int i = 0; i < NUM_KEYS; i++) begin
				key_store[i] <= 48'h0;
			end
		end else if (wr_acc) begin
			if (paddr == ADDR_KEY_INDEX) begin
				key_index <= pwdata[5:0];
			end else if (paddr == ADDR_KEY_LO) begin
				key_lo <= pwdata;
			end else if ((paddr == ADDR_KEY_HI) && (key_index <= KEY_MAX)) begin
				key_store[key_index] <= {pwdata[15:0], key_lo};
			end
		end
	end
	// Data buffer; software writes are dropped while a command owns it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < BUF_BYTES; i++) begin
				buf_mem[i] <= 8'h00;
			end
		end else if (wr_acc && !busy && (paddr[11:8] == ADDR_BUF_PAGE)) begin
			for (int i = 0; i < 4; i++) begin
				buf_mem[{paddr[7:2], 2'(i)}] <= pwdata[8*i +: 8];
			end
		end else if ((state == S_XFER) && tag_done && tag_ok &&
			(cur_cmd == CMD_READ_DATA)) begin
			// RL19: block bytes stored in order from the pointer
			for (int i = 0; i < BLOCK_BYTES; i++) begin
				buf_mem[8'(ptr + 8'(i))] <= tag_rdata[8*i +: 8];
			end
		end
	end
	// Write data is gathered before each write request and then held.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tag_wdata <= 128'h0;
		end else if (state == S_CHECK) begin
			// RL12: block data comes from the buffer at the pointer
			for (int i = 0; i < BLOCK_BYTES; i++) begin
				tag_wdata[8*i +: 8] <= buf_mem[8'(ptr + 8'(i))];
			end
		end
	end
	// Command sequencer: authenticate per sector, then move one block a time.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= S_IDLE;
			busy <= 1'b0;
			result <= RESULT_RESET;
			cur_cmd <= 8'h00;
			blk <= 8'h00;
			cnt <= 8'h00;
			ptr <= 8'h00;
			authed <= 1'b0;
			auth_sector <= 6'h0;
			tag_req <= 1'b0;
			tag_op <= OP_AUTH;
			tag_block <= 8'h00;
			tag_key <= 48'h0;
			tag_key_b <= 1'b0;
		end else begin
			case (state)
				S_IDLE: begin
					if (start_cmd) begin
						cur_cmd <= pwdata[7:0];
						blk <= arg_mem[ARG_START];
						cnt <= arg_mem[ARG_COUNT];
						ptr <= arg_mem[ARG_OFFSET];
						authed <= 1'b0;
						// RL7: bit 7 picks key B, else key A
						tag_key_b <= arg_mem[ARG_KEYSEL][KEYSEL_B_BIT];
						// RL8: inline key replaces the stored one
						tag_key <= key_inline ? inline_key : stored_key;
						if (arg_err != 8'h00) begin
							// Bad arguments finish at once with no tag traffic.
							result <= arg_err;
						end else begin
							// RL1: write or data read begins
							busy <= 1'b1;
							state <= S_CHECK;
						end
					end
				end
				S_CHECK: begin
					if ((cur_cmd == CMD_READ_DATA) && tbrw_trailer(blk)) begin
						// RL18: trailers are passed over without counting
						blk <= blk + 8'h01;
					end else if (!authed || (tbrw_sector(blk) != auth_sector)) begin
						// RL10 RL13: authenticate each sector first
						tag_req <= 1'b1;
						tag_op <= OP_AUTH;
						tag_block <= blk;
						state <= S_AUTH;
					end else begin
						tag_req <= 1'b1;
						tag_op <= (cur_cmd == CMD_WRITE) ? OP_WRITE : OP_READ;
						tag_block <= blk;
						state <= S_XFER;
					end
				end
				S_AUTH: begin
					if (tag_done) begin
						tag_req <= 1'b0;
						if (tag_ok) begin
							authed <= 1'b1;
							auth_sector <= tbrw_sector(tag_block);
							state <= S_CHECK;
						end else begin
							// RL11 RL16: abort on failed authentication
							result <= RES_AUTH;
							busy <= 1'b0;
							state <= S_IDLE;
						end
					end
				end
				S_XFER: begin
					if (tag_done) begin
						tag_req <= 1'b0;
						if (!tag_ok) begin
							// RL15 RL20: failed block gives an error
							result <= RES_TAG;
							busy <= 1'b0;
							state <= S_IDLE;
						end else if (cnt == 8'h01) begin
							// RL14: all blocks done, report success
							result <= RES_OK;
							busy <= 1'b0;
							state <= S_IDLE;
						end else begin
							// RL17: continue with the next block
							cnt <= cnt - 8'h01;
							ptr <= ptr + BLOCK_STEP;
							blk <= blk + 8'h01;
							state <= S_CHECK;
						end
					end
				end
				default: begin
					state <= S_IDLE;
					busy <= 1'b0;
					tag_req <= 1'b0;
				end
			endcase
		end
	end
	// Checks on the sequencer and its tag requests.
	default clocking tbrw_cb @(posedge clk); endclocking
	default disable iff (rst);
	// A command that passed its argument checks.
	wire logic start_ok = start_cmd && (arg_err == 8'h00);
	write_start_a: assert property ( // RL1
		start_ok && (pwdata[7:0] == CMD_WRITE) |=> busy && state == S_CHECK)
		else $error("write command did not start");
	read_start_a: assert property ( // RL2
		start_ok && (pwdata[7:0] == CMD_READ_DATA) |=>
		busy && cur_cmd == CMD_READ_DATA)
		else $error("data read command did not start");
	arg_unpack_a: assert property ( // RL3
		start_ok |=> blk == $past(arg_mem[ARG_START]) &&
		cnt == $past(arg_mem[ARG_COUNT]) && ptr == $past(arg_mem[ARG_OFFSET]))
		else $error("arguments unpacked wrongly");
	stored_key_a: assert property ( // RL6
		start_ok && !key_inline |=> tag_key == $past(stored_key))
		else $error("stored key not selected");
	key_type_a: assert property ( // RL7
		start_cmd |=> tag_key_b == $past(arg_mem[ARG_KEYSEL][KEYSEL_B_BIT]))
		else $error("key type wrong");
	inline_key_a: assert property ( // RL8
		start_cmd && key_inline |=> tag_key[7:0] == $past(arg_mem[ARG_KEY]))
		else $error("inline key not used low byte first");
	auth_before_a: assert property ( // RL10
		tag_req && tag_op != OP_AUTH |->
		authed && tbrw_sector(tag_block) == auth_sector)
		else $error("transfer without sector authentication");
	auth_fail_a: assert property ( // RL11
		state == S_AUTH && tag_done && !tag_ok |=>
		!busy && result == RES_AUTH && !tag_req)
		else $error("authentication failure not reported");
	write_data_a: assert property ( // RL12
		tag_req && tag_op == OP_WRITE |-> tag_wdata[7:0] == buf_mem[ptr])
		else $error("write data not from buffer pointer");
	done_ok_a: assert property ( // RL14
		state == S_XFER && tag_done && tag_ok && cnt == 8'h01 |=>
		!busy && result == RES_OK)
		else $error("success not reported");
	block_err_a: assert property ( // RL15
		state == S_XFER && tag_done && !tag_ok |=> !busy && result == RES_TAG)
		else $error("block failure not reported");
	trailer_skip_a: assert property ( // RL18
		tag_req && tag_op == OP_READ |-> !tbrw_trailer(tag_block))
		else $error("trailer block read");
	read_store_a: assert property ( // RL19
		state == S_XFER && tag_done && tag_ok && cur_cmd == CMD_READ_DATA |=>
		buf_mem[$past(ptr)] == $past(tag_rdata[7:0]))
		else $error("read data not stored at pointer");
	result_hold_a: assert property ( // RL21
		busy ##1 busy |-> $stable(result))
		else $error("result changed during a command");
	write_done_c: cover property (
		state == S_XFER && tag_done && tag_ok && cnt == 8'h01 &&
		cur_cmd == CMD_WRITE);
	read_done_c: cover property (
		state == S_XFER && tag_done && tag_ok && cnt == 8'h01 &&
		cur_cmd == CMD_READ_DATA);
	auth_fail_c: cover property (state == S_AUTH && tag_done && !tag_ok);
	reauth_c: cover property (state == S_CHECK && authed ##1 state == S_AUTH);
endmodule // tbrw_block_cmds

//--- verification/tbrw_tag_model.sv
// Purpose: Behavioural tag in the field, answering the block command link.
// Assumes: One request at a time; each answer comes after a set delay.
// Notes: A transfer is refused unless its own sector was opened first.
`timescale 1ns/1ps
module tbrw_tag_model import tbrw_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic tag_req,
	input wire logic [1:0] tag_op,
	input wire logic [7:0] tag_block,
	input wire logic [47:0] tag_key,
	input wire logic tag_key_b,
	input wire logic [127:0] tag_wdata,
	output logic tag_done,
	output logic tag_ok,
	output logic [127:0] tag_rdata,
	input wire logic [47:0] good_key,
	input wire logic good_key_b,
	input wire logic [8:0] fail_blk,
	input wire logic [7:0] delay
);
	logic [127:0] mem [256]; // Tag memory, one entry per block.
	logic [7:0] cnt; // Cycles waited on the current request.
	logic [7:0] auth_sec; // Sector named by the last authentication, good or failed.
	logic auth_vld; // High while auth_sec is open.
	logic auth_ok; // The offered key and kind match the tag and the block is not fail_blk.
	logic xfer_ok; // The block may be moved now.
	int n_auth, n_write, n_read; // Requests seen, by kind.
	// Own sector numbering, kept apart from the design's helper on purpose.
	function automatic logic [7:0] sec_of(input logic [7:0] b);
		sec_of = (b < 8'h80) ? {2'h0, b[7:2]} : {4'h8, b[7:4]};
	endfunction
	assign auth_ok = tag_key == good_key && tag_key_b == good_key_b &&
		{1'b0, tag_block} != fail_blk;
	assign xfer_ok = auth_vld && sec_of(tag_block) == auth_sec &&
		{1'b0, tag_block} != fail_blk;
	// Data lines wander between answers, so stale data never looks valid.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tag_done <= 1'b0;
			tag_ok <= 1'b0;
			tag_rdata <= '0;
			cnt <= 8'h00;
			auth_vld <= 1'b0;
			auth_sec <= 8'h00;
			n_auth <= 0;
			n_write <= 0;
			n_read <= 0;
			for (int i = 0; i < 256; i++) mem[i] <= {16{i[7:0]}};
		end else if (tag_done || !tag_req || cnt != delay) begin
			tag_done <= 1'b0;
			cnt <= (tag_req && !tag_done) ? cnt + 8'h01 : 8'h00;
			tag_rdata <= ~tag_rdata;
		end else begin
			tag_done <= 1'b1;
			tag_rdata <= mem[tag_block];
			if (tag_op == OP_AUTH) begin
				n_auth <= n_auth + 1;
				tag_ok <= auth_ok;
				auth_vld <= auth_ok;
				auth_sec <= sec_of(tag_block);
			end else begin
				tag_ok <= xfer_ok;
				n_write <= n_write + int'(tag_op == OP_WRITE);
				n_read <= n_read + int'(tag_op == OP_READ);
				if (tag_op == OP_WRITE && xfer_ok) mem[tag_block] <= tag_wdata;
			end
		end
	end
endmodule // tbrw_tag_model

//--- verification/tb_tag_block_write_read_cmds.sv
// Purpose: Self-checking bench for the block write and data read commands.
// Assumes: APB answers after setup; the tag model sits on the link.
// Notes: Expected data follow from a fixed buffer pattern and known keys.
`timescale 1ns/1ps
module tb_tag_block_write_read_cmds import tbrw_pkg::*; ;
	localparam logic [47:0] K1 = 48'h1a2b3c4d5e6f; // Stored in slot 5.
	localparam logic [47:0] K2 = 48'h0102030405a6; // Sent inline.
	localparam logic [47:0] K3 = 48'hf0e1d2c3b4a5; // Stored in slot 39.
	logic clk, rst, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic tag_req, tag_key_b, tag_done, tag_ok, good_key_b;
	logic [1:0] tag_op;
	logic [7:0] tag_block, delay;
	logic [47:0] tag_key, good_key;
	logic [127:0] tag_wdata, tag_rdata;
	logic [8:0] fail_blk;
	int n_mismatch, n_checks, a0, w0, r0;
	tbrw_block_cmds dut (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tag_req(tag_req), .tag_op(tag_op), .tag_block(tag_block),
		.tag_key(tag_key), .tag_key_b(tag_key_b), .tag_wdata(tag_wdata),
		.tag_done(tag_done), .tag_ok(tag_ok), .tag_rdata(tag_rdata));
	tbrw_tag_model u_tag (.clk(clk), .rst(rst), .tag_req(tag_req),
		.tag_op(tag_op), .tag_block(tag_block), .tag_key(tag_key),
		.tag_key_b(tag_key_b), .tag_wdata(tag_wdata), .tag_done(tag_done),
		.tag_ok(tag_ok), .tag_rdata(tag_rdata), .good_key(good_key),
		.good_key_b(good_key_b), .fail_blk(fail_blk), .delay(delay));
	// Free-running clock at 200 MHz.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Compares one value and counts the outcome.
	task automatic chk(input string what, input logic [127:0] seen,
		input logic [127:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One APB transfer; answer, data and error are all taken at one edge.
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		int t;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			$display("[FAIL] pready expected 1 seen %b", pready);
		end
		// Request is released only after the edge that accepted it.
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Loads the argument list, little endian, then the command code.
	task automatic start_cmd(input logic [7:0] c, b, n, o, k,
		input logic [47:0] key);
		apb(ADDR_ARG0, 1'b1, {k, o, n, b});
		apb(ADDR_ARG1, 1'b1, key[31:0]);
		apb(ADDR_ARG2, 1'b1, {16'h0000, key[47:32]});
		apb(ADDR_COMMAND, 1'b1, {24'h000000, c});
	endtask
	// Polls busy under a bound, then leaves the result code in rd.
	task automatic finish_cmd();
		int t;
		t = 0;
		do begin
			apb(ADDR_STATUS, 1'b0, 32'h0);
			t++;
		end while (rd[0] !== 1'b0 && t < 500);
		apb(ADDR_RESULT, 1'b0, 32'h0);
	endtask
	// Commits a key to a stored slot.
	task automatic load_key(input logic [5:0] idx, input logic [47:0] key);
		apb(ADDR_KEY_INDEX, 1'b1, {26'h0, idx});
		apb(ADDR_KEY_LO, 1'b1, key[31:0]);
		apb(ADDR_KEY_HI, 1'b1, {16'h0000, key[47:32]});
	endtask
	function automatic logic [7:0] bufb(input int i);
		bufb = i[7:0] ^ 8'ha5;
	endfunction
	// Block image of sixteen buffer bytes from offset o.
	function automatic logic [127:0] blk_exp(input int o);
		for (int k = 0; k < 16; k++) blk_exp[8*k +: 8] = bufb(o + k);
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// A hang is cut short well past the expected run length.
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		summarize();
	end
	// Main sequence of tests.
	initial begin
		logic [31:0] etab [3];
		logic [7:0] cmds [2];
		logic [127:0] eb [3];
		etab = '{{CMD_READ_DATA, 8'h00, 8'h05, RES_ARG},
			{CMD_WRITE, 8'h01, 8'h28, RES_ARG}, {8'h07, 8'h01, 8'h05, RES_CMD}};
		cmds = '{CMD_WRITE, CMD_READ_DATA};
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{good_key, good_key_b, delay} = '0;
		fail_blk = 9'h100;
		n_mismatch = 0;
		n_checks = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		apb(ADDR_RESULT, 1'b0, 32'h0);
		chk("result reset", rd, {24'h0, RESULT_RESET});
		apb(12'h040, 1'b0, 32'h0);
		chk("unmapped", {er, rd}, {1'b1, 32'h0});
		load_key(6'd5, K1);
		load_key(6'd39, K3);
		for (int w = 0; w < 64; w++) begin
			apb(12'h100 + 12'(4*w), 1'b1,
				{bufb(4*w+3), bufb(4*w+2), bufb(4*w+1), bufb(4*w)});
		end
		$display("test setup done");
		// Refused argument sets answer at once; the last leaves RES_CMD.
		for (int i = 0; i < 3; i++) begin
			start_cmd(etab[i][31:24], 8'h00, etab[i][23:16], 8'h00,
				etab[i][15:8], K1);
			finish_cmd();
			chk("refused", rd[7:0], etab[i][7:0]);
		end
		$display("test refusals done");
		// Slow tag, three blocks crossing a sector, a read command sent while busy.
		good_key <= K1;
		delay <= 8'd12;
		a0 = u_tag.n_auth;
		r0 = u_tag.n_read;
		start_cmd(CMD_WRITE, 8'h02, 8'h03, 8'h10, 8'h05, K1);
		apb(ADDR_STATUS, 1'b0, 32'h0);
		chk("busy", rd[0], 1'b1);
		apb(ADDR_COMMAND, 1'b1, {24'h0, CMD_READ_DATA});
		apb(ADDR_RESULT, 1'b0, 32'h0);
		chk("result held", rd[7:0], RES_CMD);
		finish_cmd();
		chk("write ok", rd[7:0], RES_OK);
		for (int b = 0; b < 3; b++) begin
			chk("write blk", u_tag.mem[2+b], blk_exp(16+16*b));
		end
		chk("auth count", u_tag.n_auth - a0, 2);
		chk("cmd ignored", u_tag.n_read - r0, 0);
		$display("test multi write done");
		// Prompt tag, inline key B, least significant byte first.
		good_key <= K2;
		good_key_b <= 1'b1;
		delay <= 8'd0;
		start_cmd(CMD_WRITE, 8'h81, 8'h01, 8'h00, 8'hc0, K2);
		finish_cmd();
		chk("inline ok", rd[7:0], RES_OK);
		chk("inline blk", u_tag.mem[8'h81], blk_exp(0));
		$display("test inline key done");
		// Slot 39 as key B; trailer 0x03 skipped, blocks packed at 0x40.
		good_key <= K3;
		delay <= 8'd3;
		r0 = u_tag.n_read;
		start_cmd(CMD_READ_DATA, 8'h02, 8'h03, 8'h40, 8'ha7, 48'h0);
		finish_cmd();
		chk("read ok", rd[7:0], RES_OK);
		chk("read count", u_tag.n_read - r0, 3);
		eb = '{blk_exp(16), blk_exp(48), {16{8'h05}}};
		for (int w = 0; w < 12; w++) begin
			apb(12'h140 + 12'(4*w), 1'b0, 32'h0);
			chk("read buf", rd, eb[w/4][32*(w%4) +: 32]);
		end
		$display("test data read done");
		// Wrong key: both commands stop, nothing is written.
		good_key <= K2;
		good_key_b <= 1'b0;
		w0 = u_tag.n_write;
		for (int i = 0; i < 2; i++) begin
			start_cmd(cmds[i], 8'h08, 8'h01, 8'h00, 8'h05, K1);
			finish_cmd();
			chk("auth fail", rd[7:0], RES_AUTH);
		end
		chk("no write", u_tag.n_write - w0, 0);
		$display("test auth fail done");
		// The second block of a pair fails on the tag.
		good_key <= K1;
		fail_blk <= 9'h006;
		for (int i = 0; i < 2; i++) begin
			start_cmd(cmds[i], 8'h05, 8'h02, 8'h00, 8'h05, K1);
			finish_cmd();
			chk("block fail", rd[7:0], RES_TAG);
		end
		$display("test block fail done");
		summarize();
	end
endmodule // tb_tag_block_write_read_cmds
